// [inc/sim_pkg.sv]
// What this block does
// R1: watchdog underflow drives the reset pin low for at least the minimum pulse.
// R2: while supply is below threshold, hold static reset and drive reset pin low.
// R3: with the undervoltage detector option off, its reset flag is don't-care.
// R4: bit 5 follows the selected comparator live: 1 below threshold, 0 above.
// R5: auxiliary monitor flag and interrupt work only with undervoltage detector on.
// R6: bit 7 selects the source: 0 main supply, 1 external voltage pin.
// R7: with bit 6 set, each change of the warning flag raises an interrupt.
// R8: the warning request clears itself when its service routine is entered.
// R9: a crossing during the 256 or 4096 cycle reset delay raises no interrupt.
// R10: enabling the warning interrupt while below threshold raises one immediately.
// R11: bit 3 is reserved: reads zero, software writes zero.
// R12: bit 4 is set by an undervoltage reset, cleared only by writing zero.
// R13: lost main clock switches the cpu to the safe oscillator, back on recovery.
// R14: bit 1 sets while safe clock is used, clears on a read after recovery.
// R15: bit 2 enables the clock failure interrupt; no effect with supervisor off.
// R16: with the clock supervisor option off, bit 1 reads zero.
// R17: main clock glitch filtering is active only when the PLL is enabled.
// R18: both interrupts wake from wait; neither wakes from halt.
// R19: halt stops the supervisor; config resumes after interrupt wake, reset clears it.
// R20: an interrupt needs its enable set and the global mask cleared.
// R21: reset clears all bits except the two reset-cause flags, bits 4 and 0.
// R22: bit 0 sets on watchdog reset, clears by writing zero or undervoltage reset.
// R23: the undervoltage flag survives later external or watchdog resets.
// R24: minimum watchdog reset pulse is a parameter counted in cpu cycles.
package sim_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ICSR_OFFSET = 8'h00;
  localparam int MIN_RST_PULSE = 16;
  localparam int RST_DELAY_SHORT = 256;
  localparam int RST_DELAY_LONG = 4096;
  localparam int CNT_W = 13;
  // reset values of the software-owned bits and the clock failure flag
  localparam logic SRC_SEL_RST = 1'b0;
  localparam logic V_IE_RST = 1'b0;
  localparam logic C_IE_RST = 1'b0;
  localparam logic C_DET_RST = 1'b0;
  // field positions
  localparam int SRC_SEL_BIT = 7;
  localparam int V_IE_BIT = 6;
  localparam int V_FLAG_BIT = 5;
  localparam int UV_FLAG_BIT = 4;
  localparam int C_IE_BIT = 2;
  localparam int C_DET_BIT = 1;
  localparam int WD_FLAG_BIT = 0;

  typedef struct packed {
    logic monitor_source_select;
    logic voltage_warn_irq_enable;
    logic voltage_warn_flag;
    logic undervoltage_reset_flag;
    logic rsvd;
    logic clock_fail_irq_enable;
    logic clock_fail_detected;
    logic watchdog_reset_flag;
  } icsr_s;

  typedef struct packed {
    logic uv_en;
    logic css_en;
    logic pll_en;
    logic long_delay;
  } opt_s;
endpackage

// [rtl/system_integrity_monitor.sv]
`timescale 1ns/1ps
module system_integrity_monitor #(
  parameter int MIN_PULSE = sim_pkg::MIN_RST_PULSE,
  parameter int DELAY_SHORT = sim_pkg::RST_DELAY_SHORT,
  parameter int DELAY_LONG = sim_pkg::RST_DELAY_LONG
) (
  input wire logic CLK_IN, // cpu clock, 125 MHz
  input wire logic RESET_IN, // sync reset from the sequencer
  input wire logic CE_IN, // clock enable, freezes all state while RESET_IN is low
  input wire sim_pkg::opt_s OPT_IN, // option straps, caught during reset
  input wire logic PSEL_IN, // apb select
  input wire logic PENABLE_IN, // apb enable
  input wire logic PWRITE_IN, // apb direction
  input wire logic [sim_pkg::ADDR_W-1:0] PADDR_IN, // apb byte address
  input wire logic [31:0] PWDATA_IN, // apb write data
  output logic PREADY_OUT, // apb ready
  output logic PSLVERR_OUT, // apb error on unmapped address
  output logic [31:0] PRDATA_OUT, // apb read data
  input wire logic SUPPLY_LOW_IN, // async: supply below reset threshold
  input wire logic VDD_WARN_IN, // async: main supply warning comparator
  input wire logic EXT_WARN_IN, // async: external pin warning comparator
  input wire logic MAIN_CLK_OK_IN, // async: main oscillator present
  input wire logic WDG_UNDERFLOW_IN, // watchdog underflow pulse
  input wire logic GLOBAL_MASK_IN, // cpu global interrupt mask
  input wire logic WAIT_IN, // cpu in wait mode
  input wire logic HALT_IN, // cpu in halt mode
  input wire logic V_ACK_IN, // pulse: warning service routine entered
  input wire logic C_ACK_IN, // pulse: clock failure routine entered
  output logic RST_PIN_OUT, // reset pin output level, always low
  output logic RST_PIN_OE_OUT, // reset pin pulled low while high
  output logic CPU_RST_OUT, // cpu held in reset incl. delay phase
  output logic CLK_SEL_SAFE_OUT, // cpu clock taken from safe oscillator
  output logic SAFE_OSC_EN_OUT, // safe oscillator running
  output logic GLITCH_FILT_EN_OUT, // main clock glitch filter on
  output logic VOLT_WARN_IRQ_OUT, // voltage warning interrupt request
  output logic CLK_FAIL_IRQ_OUT, // clock failure interrupt request
  output logic WAKE_OUT // wake request out of wait
);

  function automatic logic reg_hit(input logic [sim_pkg::ADDR_W-1:0] a);
    reg_hit = (a == sim_pkg::ICSR_OFFSET);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers and option capture

  logic [3:0] sync1;
  logic [3:0] sync2;
  sim_pkg::opt_s opt;

  always_ff @(posedge CLK_IN) begin
    if (CE_IN) begin
      sync1 <= {MAIN_CLK_OK_IN, EXT_WARN_IN, VDD_WARN_IN, SUPPLY_LOW_IN};
      sync2 <= sync1;
    end
  end

  // straps are sampled while the sequencer holds reset, then stay put
  always_ff @(posedge CLK_IN) begin
    if (CE_IN && RESET_IN) begin
      opt <= OPT_IN;
    end
  end

  logic supply_low;
  logic vdd_warn;
  logic ext_warn;
  logic main_ok;
  logic uv_active;
  assign supply_low = sync2[0];
  assign vdd_warn = sync2[1];
  assign ext_warn = sync2[2];
  assign main_ok = sync2[3];
  assign uv_active = opt.uv_en && supply_low; // R2

  ////////////////////////////////////////////////////////////////////////
  // reset generation

  logic [sim_pkg::CNT_W-1:0] wdg_cnt;
  logic [sim_pkg::CNT_W-1:0] dly_cnt;
  logic [sim_pkg::CNT_W-1:0] next_wdg_cnt;
  logic [sim_pkg::CNT_W-1:0] next_dly_cnt;
  logic next_pin_drv;

  always_comb begin
    next_wdg_cnt = wdg_cnt;
    if (WDG_UNDERFLOW_IN) begin
      next_wdg_cnt = sim_pkg::CNT_W'(MIN_PULSE); // R1 R24
    end else if (uv_active) begin
      // power-on passes here too, so the counter leaves its unknown start value
      next_wdg_cnt = '0;
    end else if (wdg_cnt != '0) begin
      next_wdg_cnt = wdg_cnt - 1'b1;
    end
    next_pin_drv = uv_active || (next_wdg_cnt != '0); // R1 R2
    next_dly_cnt = dly_cnt;
    if (next_pin_drv) begin
      next_dly_cnt = opt.long_delay ? sim_pkg::CNT_W'(DELAY_LONG) : sim_pkg::CNT_W'(DELAY_SHORT);
    end else if (dly_cnt != '0) begin
      next_dly_cnt = dly_cnt - 1'b1;
    end
  end

  // not cleared by RESET_IN: the sequencer resets because of this pulse
  always_ff @(posedge CLK_IN) begin
    if (CE_IN) begin
      wdg_cnt <= next_wdg_cnt;
      dly_cnt <= next_dly_cnt;
      RST_PIN_OE_OUT <= next_pin_drv;
      // the old count keeps the cpu in reset for the full delay after the pin lets go
      CPU_RST_OUT <= next_pin_drv || (dly_cnt != '0);
      RST_PIN_OUT <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave and register

  // each field is its own flop so that every process owns what it writes
  logic src_sel;
  logic v_ie;
  logic v_flag;
  logic uv_flag;
  logic c_ie;
  logic c_det;
  logic wd_flag;
  sim_pkg::icsr_s icsr;
  always_comb begin
    icsr = '0;
    icsr.monitor_source_select = src_sel;
    icsr.voltage_warn_irq_enable = v_ie;
    icsr.voltage_warn_flag = v_flag;
    icsr.undervoltage_reset_flag = uv_flag;
    icsr.rsvd = 1'b0; // R11
    icsr.clock_fail_irq_enable = c_ie;
    icsr.clock_fail_detected = c_det;
    icsr.watchdog_reset_flag = wd_flag;
  end
  logic acc_edge;
  logic wr_hit;
  logic rd_hit;
  assign acc_edge = CE_IN && PSEL_IN && PENABLE_IN && PREADY_OUT;
  assign wr_hit = acc_edge && PWRITE_IN && reg_hit(PADDR_IN);
  assign rd_hit = acc_edge && !PWRITE_IN && reg_hit(PADDR_IN);

  sim_pkg::icsr_s rd_view;
  always_comb begin
    rd_view = icsr;
    rd_view.rsvd = 1'b0; // R11
    rd_view.clock_fail_detected = icsr.clock_fail_detected && opt.css_en; // R16
  end

  // one wait-free access phase: ready is raised by the setup cycle
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= 32'h00000000;
    end else if (CE_IN) begin
      PREADY_OUT <= PSEL_IN && !PENABLE_IN;
      PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !reg_hit(PADDR_IN);
      if (PSEL_IN && !PENABLE_IN && !PWRITE_IN && reg_hit(PADDR_IN)) begin
        PRDATA_OUT <= {24'h000000, rd_view};
      end else begin
        PRDATA_OUT <= 32'h00000000;
      end
    end
  end

  // software bits: halt leaves them untouched, reset clears them
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      src_sel <= sim_pkg::SRC_SEL_RST; // R21
      v_ie <= sim_pkg::V_IE_RST;
      c_ie <= sim_pkg::C_IE_RST;
    end else if (wr_hit) begin
      src_sel <= PWDATA_IN[sim_pkg::SRC_SEL_BIT]; // R6
      v_ie <= PWDATA_IN[sim_pkg::V_IE_BIT];
      c_ie <= PWDATA_IN[sim_pkg::C_IE_BIT]; // R15
    end
  end

  // reset-cause flags ride through RESET_IN; hardware set beats a write of zero
  always_ff @(posedge CLK_IN) begin
    if (CE_IN) begin
      if (uv_active) begin
        uv_flag <= 1'b1; // R12 R23 R3
      end else if (wr_hit && !PWDATA_IN[sim_pkg::UV_FLAG_BIT]) begin
        uv_flag <= 1'b0;
      end
      if (WDG_UNDERFLOW_IN) begin
        wd_flag <= 1'b1; // R22
      end else if (uv_active) begin
        wd_flag <= 1'b0;
      end else if (wr_hit && !PWDATA_IN[sim_pkg::WD_FLAG_BIT]) begin
        wd_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // auxiliary voltage monitor

  logic next_v_flag;
  logic v_ie_d;
  logic v_pend;
  logic v_set;
  assign next_v_flag = opt.uv_en && (icsr.monitor_source_select ? ext_warn : vdd_warn); // R4 R5 R6
  // no request while the cpu sits in reset or its delay phase
  assign v_set = opt.uv_en && !CPU_RST_OUT && icsr.voltage_warn_irq_enable
    && ((next_v_flag != icsr.voltage_warn_flag) || !v_ie_d && icsr.voltage_warn_flag); // R7 R9 R10

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      v_flag <= 1'b0;
      v_ie_d <= 1'b0;
      v_pend <= 1'b0;
    end else if (CE_IN) begin
      v_flag <= next_v_flag; // R4
      v_ie_d <= icsr.voltage_warn_irq_enable;
      if (v_set) begin
        v_pend <= 1'b1;
      end else if (V_ACK_IN) begin
        v_pend <= 1'b0; // R8
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock supervisor

  logic css_run;
  logic c_pend;
  assign css_run = opt.css_en && !HALT_IN; // R19

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      CLK_SEL_SAFE_OUT <= 1'b0;
      SAFE_OSC_EN_OUT <= 1'b0;
      GLITCH_FILT_EN_OUT <= 1'b0;
      c_det <= sim_pkg::C_DET_RST;
      c_pend <= 1'b0;
    end else if (CE_IN) begin
      CLK_SEL_SAFE_OUT <= css_run && !main_ok; // R13 R19
      SAFE_OSC_EN_OUT <= css_run;
      GLITCH_FILT_EN_OUT <= opt.pll_en; // R17
      if (CLK_SEL_SAFE_OUT) begin
        c_det <= 1'b1; // R14
      end else if (rd_hit && main_ok) begin
        c_det <= 1'b0; // R14
      end
      if (opt.css_en && CLK_SEL_SAFE_OUT && !icsr.clock_fail_detected) begin
        c_pend <= 1'b1; // R15
      end else if (C_ACK_IN) begin
        c_pend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt requests and wake

  logic v_req;
  logic c_req;
  assign v_req = v_pend && icsr.voltage_warn_irq_enable && opt.uv_en;
  assign c_req = c_pend && icsr.clock_fail_irq_enable && opt.css_en; // R15

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      VOLT_WARN_IRQ_OUT <= 1'b0;
      CLK_FAIL_IRQ_OUT <= 1'b0;
      WAKE_OUT <= 1'b0;
    end else if (CE_IN) begin
      VOLT_WARN_IRQ_OUT <= v_req && !GLOBAL_MASK_IN; // R20
      CLK_FAIL_IRQ_OUT <= c_req && !GLOBAL_MASK_IN; // R20
      // halt ignores both sources, wait is left on either
      WAKE_OUT <= (v_req || c_req) && WAIT_IN && !HALT_IN; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  chk_wdg_pin_low: assert property ((WDG_UNDERFLOW_IN && CE_IN) |=> RST_PIN_OE_OUT) // R1
    else $error("watchdog underflow did not pull reset pin");
  chk_wdg_pulse_len: assert property ($rose(RST_PIN_OE_OUT) && !uv_active |-> RST_PIN_OE_OUT [*8]) // R1
    else $error("reset pin pulse too short");
  chk_uv_static: assert property ((uv_active && CE_IN) |=> RST_PIN_OE_OUT && CPU_RST_OUT) // R2
    else $error("undervoltage did not hold reset");
  chk_rsvd_zero: assert property (PREADY_OUT |-> PRDATA_OUT[3] == 1'b0) // R11
    else $error("reserved bit read nonzero");
  chk_css_off_zero: assert property ((!opt.css_en && PREADY_OUT) |-> !PRDATA_OUT[sim_pkg::C_DET_BIT]) // R16
    else $error("clock fail flag visible with supervisor off");
  chk_vwarn_edge: assert property ((v_set && CE_IN) |=> v_pend) // R7
    else $error("warning change lost");
  chk_vwarn_ack: assert property ((V_ACK_IN && !v_set && CE_IN) |=> !v_pend) // R8
    else $error("warning request not cleared on service");
  chk_irq_mask: assert property ((VOLT_WARN_IRQ_OUT || CLK_FAIL_IRQ_OUT) && $past(CE_IN) |-> $past(!GLOBAL_MASK_IN)) // R20
    else $error("interrupt raised while masked");
  chk_no_halt_wake: assert property (WAKE_OUT && $past(CE_IN) |-> $past(!HALT_IN && WAIT_IN)) // R18
    else $error("wake outside wait");
  chk_safe_clk: assert property (CLK_SEL_SAFE_OUT && $past(CE_IN) |-> $past(opt.css_en && !HALT_IN && !main_ok)) // R13
    else $error("safe clock selected without cause");
  chk_no_delay_irq: assert property ((CPU_RST_OUT && CE_IN) |=> $stable(v_pend) || !v_pend) // R9
    else $error("warning request during reset delay");

  cov_wdg_reset: cover property ($rose(RST_PIN_OE_OUT) && !uv_active);
  cov_clk_fail: cover property ($rose(CLK_FAIL_IRQ_OUT));
  cov_volt_irq: cover property ($rose(VOLT_WARN_IRQ_OUT));
  cov_reg_read: cover property (rd_hit);

endmodule // system_integrity_monitor

// [bench/cpu_irq_model.sv]
`timescale 1ns/1ps
module cpu_irq_model (
  input wire logic clk_in, // cpu clock
  input wire logic v_irq_in, // warning request
  input wire logic c_irq_in, // clock failure request
  input wire logic slow_in, // late vector fetch
  output logic v_ack_out, // warning routine entered
  output logic c_ack_out // clock failure routine entered
);
  int v_wait;
  int c_wait;
  // the core only vectors after finishing its instruction, so entry lags the request
  always_ff @(posedge clk_in) begin
    v_ack_out <= 1'b0;
    c_ack_out <= 1'b0;
    v_wait <= (v_irq_in === 1'b1) ? v_wait + 1 : 0;
    c_wait <= (c_irq_in === 1'b1) ? c_wait + 1 : 0;
    if (v_wait == (slow_in ? 6 : 1)) v_ack_out <= 1'b1;
    if (c_wait == (slow_in ? 6 : 1)) c_ack_out <= 1'b1;
  end
endmodule // cpu_irq_model

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  localparam int MINP = 8;
  localparam int DLY_LONG = 64;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, sup = 1, vw = 0, ew = 0, ck_ok = 1;
  logic wdg = 0, mask = 0, wt = 0, hlt = 0, slow = 0, va, ca, err, wake_seen = 0, virq_d = 0, cirq_d = 0;
  logic prdy, perr, rpin, roe, crst, safe, oscen, gf, virq, cirq, wake;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rd, d;
  sim_pkg::opt_s opt = sim_pkg::opt_s'(4'hE);
  int n_mismatch = 0, total_checks = 0, v_cnt = 0, c_cnt = 0, i, n, k;
  int seed = 32'hB31F5855;
  //////////////////////////////////////////////////////////////////////////////
  system_integrity_monitor #(.MIN_PULSE(MINP), .DELAY_SHORT(8), .DELAY_LONG(DLY_LONG)) i_dut (
    .CLK_IN(clk), .RESET_IN(rst), .CE_IN(1'b1), .OPT_IN(opt),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd),
    .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .PRDATA_OUT(prd),
    .SUPPLY_LOW_IN(sup), .VDD_WARN_IN(vw), .EXT_WARN_IN(ew), .MAIN_CLK_OK_IN(ck_ok),
    .WDG_UNDERFLOW_IN(wdg), .GLOBAL_MASK_IN(mask), .WAIT_IN(wt), .HALT_IN(hlt),
    .V_ACK_IN(va), .C_ACK_IN(ca), .RST_PIN_OUT(rpin), .RST_PIN_OE_OUT(roe), .CPU_RST_OUT(crst),
    .CLK_SEL_SAFE_OUT(safe), .SAFE_OSC_EN_OUT(oscen), .GLITCH_FILT_EN_OUT(gf),
    .VOLT_WARN_IRQ_OUT(virq), .CLK_FAIL_IRQ_OUT(cirq), .WAKE_OUT(wake));
  cpu_irq_model i_cpu (.clk_in(clk), .v_irq_in(virq), .c_irq_in(cirq), .slow_in(slow),
    .v_ack_out(va), .c_ack_out(ca));
  //////////////////////////////////////////////////////////////////////////////
  initial forever #4 clk = ~clk;
  // requests are counted by their rising edges, so a stuck-high line counts once
  always @(posedge clk) begin
    virq_d <= virq;
    cirq_d <= cirq;
    if (virq === 1'b1 && virq_d !== 1'b1) v_cnt <= v_cnt + 1;
    if (cirq === 1'b1 && cirq_d !== 1'b1) c_cnt <= c_cnt + 1;
    if (wake === 1'b1) wake_seen <= 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int j;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= wd;
    @(posedge clk);
    pen <= 1'b1;
    j = 0;
    // no cycle limit here: a slave that never answers is caught by the watchdog
    do begin
      @(posedge clk);
      j++;
    end while (prdy !== 1'b1);
    chk("pready_wait", 1, j);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  function logic [7:0] wexp(input logic [7:0] v);
    wexp = (v & 8'hC4) | 8'h10;
  endfunction
  task rdc(input logic [7:0] e);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl_status", {24'h0, e}, rd);
  endtask
  task automatic wcnt(input bit c, input int m);
    for (int j = 0; j < 300 && (c ? c_cnt : v_cnt) < m; j++) @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out;
  end
  initial begin
    repeat (10) @(posedge clk);
    chk("rst_oe", 1, roe);
    chk("cpu_rst", 1, crst);
    chk("rst_level", 0, rpin);
    rst <= 1'b0;
    sup <= 1'b0;
    for (i = 0; i < 200 && crst !== 1'b0; i++) @(posedge clk);
    chk("glitch_filt", 1, gf);
    rdc(8'h10);
    for (k = 0; k < 4; k++) begin
      d = $random(seed);
      slow <= d[9];
      d[4] = 1'b1;
      d[0] = 1'b1;
      d[3] = 1'b0;
      apb(1'b1, 8'h00, d);
      rdc(wexp(d[7:0]));
    end
    apb(1'b0, 8'h04, 32'h0);
    chk("slverr", 1, err);
    chk("rdata_unmapped", 0, rd);
    // warning crossing is raised while the watchdog pulse still drives the reset pin, so it must stay silent
    apb(1'b1, 8'h00, 32'h51);
    wdg <= 1'b1;
    @(posedge clk);
    wdg <= 1'b0;
    for (i = 0; i < 20 && roe !== 1'b1; i++) @(posedge clk);
    vw <= 1'b1;
    for (n = 0; n < 100 && roe === 1'b1; n++) @(posedge clk);
    chk("pulse_len", MINP, n);
    for (i = 0; i < 200 && crst !== 1'b0; i++) @(posedge clk);
    chk("v_irq_cnt", 0, v_cnt);
    rdc(8'h71);
    mask <= 1'b1;
    vw <= 1'b0;
    repeat (20) @(posedge clk);
    chk("v_irq_cnt", 0, v_cnt);
    mask <= 1'b0;
    wcnt(0, 1);
    chk("v_irq_cnt", 1, v_cnt);
    for (i = 0; i < 50 && virq !== 1'b0; i++) @(posedge clk);
    chk("v_irq", 0, virq);
    apb(1'b1, 8'h00, 32'h91);
    ew <= 1'b1;
    repeat (10) @(posedge clk);
    chk("v_irq_cnt", 1, v_cnt);
    apb(1'b1, 8'h00, 32'hD1);
    wcnt(0, 2);
    chk("v_irq_cnt", 2, v_cnt);
    ew <= 1'b0;
    wcnt(0, 3);
    chk("v_irq_cnt", 3, v_cnt);
    rdc(8'hD1);
    wt <= 1'b1;
    apb(1'b1, 8'h00, 32'h15);
    ck_ok <= 1'b0;
    wcnt(1, 1);
    chk("c_irq_cnt", 1, c_cnt);
    chk("clk_safe", 1, safe);
    rdc(8'h17);
    ck_ok <= 1'b1;
    for (i = 0; i < 50 && safe !== 1'b0; i++) @(posedge clk);
    chk("clk_safe", 0, safe);
    rdc(8'h17);
    rdc(8'h15);
    chk("wake_seen", 1, wake_seen);
    wt <= 1'b0;
    hlt <= 1'b1;
    repeat (5) @(posedge clk);
    chk("safe_osc_en", 0, oscen);
    hlt <= 1'b0;
    repeat (5) @(posedge clk);
    chk("safe_osc_en", 1, oscen);
    // second reset: supervisor and pll off, long delay; cause flags must ride through
    rst <= 1'b1;
    opt <= sim_pkg::opt_s'(4'h9);
    ck_ok <= 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("glitch_filt", 0, gf);
    chk("clk_safe", 0, safe);
    rdc(8'h11);
    apb(1'b1, 8'h00, 32'h05);
    repeat (10) @(posedge clk);
    chk("c_irq_cnt", 1, c_cnt);
    rdc(8'h05);
    wdg <= 1'b1;
    @(posedge clk);
    wdg <= 1'b0;
    for (i = 0; i < 20 && roe !== 1'b1; i++) @(posedge clk);
    for (i = 0; i < 100 && roe === 1'b1; i++) @(posedge clk);
    for (n = 0; n < 200 && crst === 1'b1; n++) @(posedge clk);
    chk("reset_delay", DLY_LONG, n);
    close_out;
  end
endmodule // tb_top
